// >>> hdl/port_io_and_memory_expansion.sv
// Four 8-bit ports with external program and data memory expansion.
// Assumes the core clock is the oscillator and pin inputs are synchronous.
`timescale 1ns/10ps
`include "port_io_regs.svh"

module port_io_and_memory_expansion
  import port_io_pkg::*;
(
  // Clock and reset.
  input wire logic i_core_clk,
  input wire logic i_reset,
  // Straps and mask options.
  input wire logic i_external_access_strap,
  input wire logic [31:0] i_post_reset_level,
  input wire logic [63:0] i_pin_option,
  // Latch writes from the core.
  input wire logic [3:0] i_byte_we,
  input wire logic [7:0] i_byte_wdata,
  input wire logic i_bit_we,
  input wire logic [4:0] i_bit_sel,
  input wire logic i_bit_wdata,
  // Latch and pin reads.
  output logic [31:0] o_port_latch,
  output logic [31:0] o_port_pins,
  // Program fetch.
  input wire logic i_pc_load,
  input wire logic [15:0] i_pc_value,
  output logic [15:0] o_fetch_addr,
  output logic o_fetch_internal,
  output logic o_code_valid,
  output logic [7:0] o_code_byte,
  output logic [11:0] o_rom_addr,
  input wire logic [7:0] i_rom_data,
  // External data access.
  input wire logic i_xdata_req,
  input wire logic i_xdata_write,
  input wire logic [15:0] i_xdata_addr,
  input wire logic [7:0] i_xdata_wdata,
  output logic o_xdata_done,
  output logic o_xdata_error,
  output logic [7:0] o_xdata_rdata,
  // Alternate functions.
  input wire logic [7:0] i_p3_alt_out,
  output logic [7:0] o_p3_alt_in,
  output logic [7:0] o_port1_extra_interrupt_inputs,
  // Pins.
  input wire logic [31:0] i_pin,
  output logic [31:0] o_pin_out,
  output logic [31:0] o_pin_oe,
  output logic [31:0] o_pin_weak_pullup,
  // Bus strobes and status.
  output logic o_address_latch_enable,
  output logic o_program_store_strobe_n,
  output logic o_ext_blocked
);

  logic [3:0] phase;
  logic [3:0] slot_phase;
  logic init_done;
  logic [7:0] port_zero_latch;
  logic [7:0] port_two_latch;
  logic [31:0] latch;
  logic [31:0] pin_value;
  logic [31:0] pin_bus;
  logic [31:0] pin_float;
  logic [15:0] pc;
  logic [15:0] bus_addr;
  bus_state_t bus_state;
  bus_state_t next_bus_state;
  logic slot_start;
  logic slot_end;
  logic cycle_start;
  logic fetch_is_internal;
  logic p0_push_pull;
  logic data_write;
  logic [7:0] data_wdata;
  logic addr_phase;
  logic rd_n;
  logic wr_n;
  logic [7:0] p3_alt_value;
  localparam logic [31:0] latch_reset_value = `LATCH_RESET;

  machine_cycle_timer u_timer (
    .i_core_clk(i_core_clk),
    .i_reset(i_reset),
    .o_phase(phase),
    .o_slot_phase(slot_phase),
    .o_ale(o_address_latch_enable)
  );

  assign slot_start = (slot_phase == 4'h0);
  assign slot_end = (slot_phase == `SLOT_LAST);
  assign cycle_start = (phase == 4'h0);

  // Post-reset levels are option straps, so they are caught after release.
  always_ff @(posedge i_core_clk or posedge i_reset) begin
    if (i_reset) begin
      init_done <= 1'b0;
    end else begin
      init_done <= 1'b1;
    end
  end

  genvar g;
  generate
    for (g = 0; g < 32; g++) begin : g_latch
      always_ff @(posedge i_core_clk or posedge i_reset) begin
        if (i_reset) begin
          latch[g] <= latch_reset_value[g];
        end else if (!init_done) begin
          latch[g] <= i_post_reset_level[g];
        end else if (i_bit_we && i_bit_sel == 5'(g)) begin
          latch[g] <= i_bit_wdata;
        end else if (i_byte_we[g / 8]) begin
          latch[g] <= i_byte_wdata[g % 8];
        end
      end
    end
  endgenerate

  assign port_zero_latch = latch[7:0];
  assign port_two_latch = latch[23:16];
  assign o_port_latch = latch;

  // Input buffers look at the pad, never at the latch.
  always_ff @(posedge i_core_clk or posedge i_reset) begin
    if (i_reset) begin
      o_port_pins <= 32'h00000000;
    end else begin
      o_port_pins <= i_pin;
    end
  end

  assign o_port1_extra_interrupt_inputs = o_port_pins[15:8];
  assign o_p3_alt_in = o_port_pins[31:24] & latch[31:24];

  always_comb begin
    p0_push_pull = 1'b0;
    for (int i = 0; i < 8; i++) begin
      if (i_pin_option[2 * i +: 2] == `OPT_PUSH_PULL) begin
        p0_push_pull = 1'b1;
      end
    end
  end

  // A push-pull port 0 cannot release the bus for read data.
  assign o_ext_blocked = p0_push_pull;

  assign fetch_is_internal = i_external_access_strap && (pc <= `INTERNAL_ROM_TOP);

  always_comb begin
    next_bus_state = bus_state;
    if (cycle_start) begin
      if (i_xdata_req && !o_ext_blocked) begin
        next_bus_state = BUS_DATA;
      end else if (fetch_is_internal) begin
        next_bus_state = BUS_IDLE;
      end else begin
        next_bus_state = BUS_FETCH;
      end
    end else if (slot_start && bus_state != BUS_DATA) begin
      next_bus_state = fetch_is_internal ? BUS_IDLE : BUS_FETCH;
    end
  end

  always_ff @(posedge i_core_clk or posedge i_reset) begin
    if (i_reset) begin
      bus_state <= BUS_IDLE;
      bus_addr <= `RESET_PC;
      data_write <= 1'b0;
      data_wdata <= 8'h00;
    end else begin
      bus_state <= next_bus_state;
      if (cycle_start && next_bus_state == BUS_DATA) begin
        bus_addr <= i_xdata_addr;
        data_write <= i_xdata_write;
        data_wdata <= i_xdata_wdata;
      end else if (slot_start && next_bus_state != BUS_DATA) begin
        bus_addr <= pc;
      end
    end
  end

  // Program counter and fetch results.
  always_ff @(posedge i_core_clk or posedge i_reset) begin
    if (i_reset) begin
      pc <= `RESET_PC;
      o_code_valid <= 1'b0;
      o_code_byte <= 8'h00;
      o_fetch_internal <= 1'b0;
    end else begin
      o_code_valid <= 1'b0;
      if (slot_end && bus_state == BUS_IDLE) begin
        o_code_valid <= 1'b1;
        o_code_byte <= i_rom_data;
        o_fetch_internal <= 1'b1;
      end else if (slot_end && bus_state == BUS_FETCH && !o_ext_blocked) begin
        o_code_valid <= 1'b1;
        o_code_byte <= i_pin[7:0];
        o_fetch_internal <= 1'b0;
      end
      if (i_pc_load) begin
        pc <= i_pc_value;
      end else if (slot_end && (bus_state == BUS_IDLE ||
                   (bus_state == BUS_FETCH && !o_ext_blocked))) begin
        pc <= pc + 16'h0001;
      end
    end
  end

  assign o_fetch_addr = pc;
  assign o_rom_addr = pc[11:0];

  // Data access completion; a blocked request is answered at the next cycle start with an error.
  always_ff @(posedge i_core_clk or posedge i_reset) begin
    if (i_reset) begin
      o_xdata_done <= 1'b0;
      o_xdata_error <= 1'b0;
      o_xdata_rdata <= 8'h00;
    end else begin
      o_xdata_done <= 1'b0;
      o_xdata_error <= 1'b0;
      if (cycle_start && i_xdata_req && o_ext_blocked) begin
        o_xdata_done <= 1'b1;
        o_xdata_error <= 1'b1;
      end else if (bus_state == BUS_DATA && phase == `PHASE_LAST) begin
        o_xdata_done <= 1'b1;
      end
      if (bus_state == BUS_DATA && !data_write && phase == `DATA_STROBE_LAST) begin
        o_xdata_rdata <= i_pin[7:0];
      end
    end
  end

  assign addr_phase = (bus_state != BUS_IDLE) && (slot_phase <= `SLOT_ALE_LAST);

  // Two program strobes per cycle of external fetch, none for internal fetch or while a data cycle owns the bus.
  assign o_program_store_strobe_n = !(bus_state == BUS_FETCH && !o_ext_blocked &&
                                      slot_phase > `SLOT_ALE_LAST);

  assign rd_n = !(bus_state == BUS_DATA && !data_write && phase >= `DATA_STROBE_FIRST &&
                  phase <= `DATA_STROBE_LAST);
  assign wr_n = !(bus_state == BUS_DATA && data_write && phase >= `DATA_STROBE_FIRST &&
                  phase <= `DATA_STROBE_LAST);

  always_comb begin
    p3_alt_value = i_p3_alt_out;
    p3_alt_value[`P3_WRITE_BIT] = wr_n;
    p3_alt_value[`P3_READ_BIT] = rd_n;
  end

  // Per-pin value, bus ownership and float selection.
  always_comb begin
    pin_value = latch;
    pin_bus = 32'h00000000;
    pin_float = 32'h00000000;
    pin_value[31:24] = latch[31:24] & p3_alt_value;
    if (bus_state != BUS_IDLE && !o_ext_blocked) begin
      pin_value[23:16] = bus_addr[15:8];
      pin_bus[23:16] = 8'hff;
      if (addr_phase) begin
        pin_value[7:0] = bus_addr[7:0];
        pin_bus[7:0] = 8'hff;
      end else if (bus_state == BUS_DATA && data_write) begin
        pin_value[7:0] = data_wdata;
        pin_bus[7:0] = 8'hff;
      end else begin
        pin_float[7:0] = 8'hff;
      end
    end else begin
      pin_value[23:16] = port_two_latch;
      // An idle standard port 0 one is driven high for two periods after it rises, then released.
      pin_value[7:0] = port_zero_latch;
    end
  end

  generate
    for (g = 0; g < 32; g++) begin : g_pin
      pin_driver u_pin (
        .i_core_clk(i_core_clk),
        .i_reset(i_reset),
        .i_option(i_pin_option[2 * g +: 2]),
        .i_keeper_allowed(g >= 8),
        .i_value(pin_value[g]),
        .i_bus(pin_bus[g]),
        .i_float(pin_float[g]),
        .o_out(o_pin_out[g]),
        .o_oe(o_pin_oe[g]),
        .o_weak(o_pin_weak_pullup[g])
      );
    end
  endgenerate

endmodule : port_io_and_memory_expansion

// >>> shared/port_io_regs.svh
// Constants for the port and memory expansion block: timing, phases, options.
// Assumes one core clock period equals one oscillator period.
`ifndef PORT_IO_REGS_SVH
`define PORT_IO_REGS_SVH

`define OSC_PERIOD_NS 10
`define STRONG_PULLUP_NS 20
`define STRONG_PULLUP_CYCLES ((`STRONG_PULLUP_NS + `OSC_PERIOD_NS - 1) / `OSC_PERIOD_NS)

`define STATES_PER_CYCLE 6
`define PERIODS_PER_STATE 2
`define PERIODS_PER_CYCLE (`STATES_PER_CYCLE * `PERIODS_PER_STATE)
`define PHASE_LAST 4'hb
`define PHASE_SLOT2 4'h6
`define SLOT_ALE_LAST 4'h1
`define SLOT_LAST 4'h5
`define DATA_STROBE_FIRST 4'h2
`define DATA_STROBE_LAST 4'h9

`define OPT_STANDARD 2'h0
`define OPT_OPEN_DRAIN 2'h1
`define OPT_PUSH_PULL 2'h2

`define INTERNAL_ROM_TOP 16'h0fff
`define RESET_PC 16'h0000
`define LATCH_RESET 32'hffffffff
`define P3_WRITE_BIT 6
`define P3_READ_BIT 7

`endif

// >>> shared/port_io_pkg.sv
// Types shared by the port and memory expansion block.
// Assumes the constants header is included by each design file.
package port_io_pkg;

  typedef logic [1:0] pin_option_t;

  typedef enum logic [1:0] {
    BUS_IDLE,
    BUS_FETCH,
    BUS_DATA
  } bus_state_t;

endpackage : port_io_pkg

// >>> hdl/machine_cycle_timer.sv
// Machine cycle timer: oscillator phase count and address latch pulse.
// Assumes the core clock is the oscillator itself.
`timescale 1ns/10ps
`include "port_io_regs.svh"

module machine_cycle_timer
  import port_io_pkg::*;
(
  // Clock and reset.
  input wire logic i_core_clk,
  input wire logic i_reset,
  // Timing outputs.
  output logic [3:0] o_phase,
  output logic [3:0] o_slot_phase,
  output logic o_ale
);

  always_ff @(posedge i_core_clk or posedge i_reset) begin
    if (i_reset) begin
      o_phase <= 4'h0;
    end else if (o_phase == `PHASE_LAST) begin
      o_phase <= 4'h0;
    end else begin
      o_phase <= o_phase + 4'h1;
    end
  end

  assign o_slot_phase = (o_phase >= `PHASE_SLOT2) ? o_phase - `PHASE_SLOT2 : o_phase;

  // Pulses in every half cycle, so the rate never depends on bus traffic.
  assign o_ale = !i_reset && (o_slot_phase <= `SLOT_ALE_LAST);

endmodule : machine_cycle_timer

// >>> hdl/pin_driver.sv
// One port pin: strong booster, keeper and pull-down with option select.
// Assumes the caller resolves bus ownership and float requests.
`timescale 1ns/10ps
`include "port_io_regs.svh"

module pin_driver
  import port_io_pkg::*;
(
  // Clock and reset.
  input wire logic i_core_clk,
  input wire logic i_reset,
  // Control.
  input wire pin_option_t i_option,
  input wire logic i_keeper_allowed,
  input wire logic i_value,
  input wire logic i_bus,
  input wire logic i_float,
  // Pin drive.
  output logic o_out,
  output logic o_oe,
  output logic o_weak
);

  logic prev;
  logic rise;
  logic [1:0] boost;

  // The rise is decoded from the live level, so the booster starts with the new one.
  assign rise = i_value && !prev;

  always_ff @(posedge i_core_clk or posedge i_reset) begin
    if (i_reset) begin
      prev <= 1'b1;
      boost <= 2'h0;
    end else begin
      prev <= i_value;
      if (rise) begin
        boost <= 2'(`STRONG_PULLUP_CYCLES - 1);
      end else if (boost != 2'h0) begin
        boost <= boost - 2'h1;
      end
    end
  end

  always_comb begin
    o_out = 1'b0;
    o_oe = 1'b0;
    case (i_option)
      `OPT_PUSH_PULL: begin
        o_out = i_value;
        o_oe = !i_float;
      end
      `OPT_OPEN_DRAIN: begin
        o_oe = !i_float && !i_value;
      end
      default: begin
        if (i_float) begin
          o_oe = 1'b0;
        end else if (!i_value) begin
          o_oe = 1'b1;
        end else begin
          o_out = 1'b1;
          o_oe = i_bus || rise || (boost != 2'h0);
        end
      end
    endcase
  end

  // The keeper only holds a one; port 0 has none, so its ones float.
  assign o_weak = i_keeper_allowed && i_value && !i_float &&
                  (i_option == `OPT_STANDARD);

endmodule : pin_driver

// >>> sim/port_io_properties.sv
// Checker for the port and memory expansion block, bound to its top.
// Assumes the pin options stay fixed between resets.
`timescale 1ns/10ps
module port_io_properties (
  // Clock and reset.
  input wire logic i_core_clk,
  input wire logic i_reset,
  // Watched ports.
  input wire logic [63:0] i_pin_option,
  input wire logic [31:0] i_pin,
  input wire logic [31:0] o_port_latch,
  input wire logic [31:0] o_port_pins,
  input wire logic [7:0] o_p3_alt_in,
  input wire logic [31:0] o_pin_out,
  input wire logic [31:0] o_pin_oe,
  input wire logic [31:0] o_pin_weak_pullup,
  input wire logic o_address_latch_enable,
  input wire logic o_program_store_strobe_n
);
  default clocking @(posedge i_core_clk);
  endclocking
  default disable iff (i_reset);
  sequence ale_cycle_s;
    o_address_latch_enable [*2] ##1 !o_address_latch_enable [*4];
  endsequence
  sequence boost_s;
    (o_pin_oe[8] && o_pin_out[8]) [*2] ##1 (!o_pin_oe[8] && o_pin_weak_pullup[8]);
  endsequence
  ale_period_a: assert property (
    $rose(o_address_latch_enable) |-> ale_cycle_s ##1 o_address_latch_enable)
    else $error("address latch pulse off its six cycle rate");
  strobe_width_a: assert property (
    $fell(o_program_store_strobe_n) |-> !o_program_store_strobe_n [*4] ##1
      o_program_store_strobe_n)
    else $error("program strobe width wrong");
  strobe_apart_a: assert property (
    !o_program_store_strobe_n |-> !o_address_latch_enable)
    else $error("program strobe overlaps address phase");
  boost_rise_a: assert property (
    $rose(o_port_latch[8]) && i_pin_option[17:16] == 2'h0 |-> boost_s)
    else $error("booster not on for two periods");
  open_drain_a: assert property (
    i_pin_option[19:18] == 2'h1 |->
      o_pin_oe[9] == !o_port_latch[9] && !(o_pin_oe[9] && o_pin_out[9]))
    else $error("open drain pin drives high");
  push_pull_a: assert property (
    i_pin_option[21:20] == 2'h2 |-> o_pin_oe[10] && o_pin_out[10] == o_port_latch[10])
    else $error("push pull pin not driven");
  alt_gate_a: assert property (
    !$past(i_reset) |-> o_p3_alt_in == ($past(i_pin[31:24]) & o_port_latch[31:24]))
    else $error("alternate input not gated by latch");
  pin_read_a: assert property (
    !$past(i_reset) |-> o_port_pins == $past(i_pin))
    else $error("pin read not from pin level");
endmodule : port_io_properties

bind port_io_and_memory_expansion port_io_properties i_props (.i_core_clk, .i_reset,
  .i_pin_option, .i_pin, .o_port_latch, .o_port_pins, .o_p3_alt_in, .o_pin_out,
  .o_pin_oe, .o_pin_weak_pullup, .o_address_latch_enable, .o_program_store_strobe_n);

// >>> sim/ext_mem_model.sv
// External memory on the expansion bus: latches the low address, answers reads.
// Assumes board pull-ups hold every released line high.
`timescale 1ns/10ps
module ext_mem_model (
  // Clock.
  input wire logic i_core_clk,
  // Board lines.
  input wire logic [31:0] i_wire,
  input wire logic i_ale,
  input wire logic i_program_store_strobe_n,
  // Drive toward port 0.
  output logic [7:0] o_data,
  output logic o_drive,
  // Last captured write.
  output logic [15:0] o_wr_addr,
  output logic [7:0] o_wr_data
);
  logic [7:0] addr_lo;
  // Only the address phase carries the low byte, so capture while the pulse is high.
  always_ff @(posedge i_core_clk) begin
    if (i_ale) begin
      addr_lo <= i_wire[7:0];
    end
    if (!i_wire[30]) begin
      o_wr_addr <= {i_wire[23:16], addr_lo};
      o_wr_data <= i_wire[7:0];
    end
  end
  // Code bytes depend on the high byte only, so a fetch is checkable at any offset.
  assign o_drive = !i_program_store_strobe_n || !i_wire[31];
  assign o_data = i_wire[23:16] ^ (i_program_store_strobe_n ? addr_lo : 8'h3c);
endmodule : ext_mem_model

// >>> sim/test_port_io_and_memory_expansion.sv
// Self-checking bench for the port and memory expansion block.
// Assumes the external memory model and pull-ups on every released line.
`timescale 1ns/10ps
module test_port_io_and_memory_expansion;
  typedef struct packed {
    logic strap;
    logic [15:0] pc;
    logic intl;
    logic [7:0] code;
  } row_t;
  logic i_core_clk, i_reset, i_external_access_strap, i_bit_we, i_bit_wdata, i_pc_load;
  logic i_xdata_req, i_xdata_write, mem_drive, xerr;
  logic o_fetch_internal, o_code_valid, o_xdata_done, o_xdata_error;
  logic o_address_latch_enable, o_program_store_strobe_n, o_ext_blocked;
  logic [31:0] i_post_reset_level, ext_low, rel_lvl, o_port_latch, o_port_pins;
  logic [31:0] o_pin_out, o_pin_oe, o_pin_weak_pullup;
  wire [31:0] i_pin;
  logic [63:0] i_pin_option;
  logic [3:0] i_byte_we;
  logic [4:0] i_bit_sel;
  logic [7:0] i_byte_wdata, o_code_byte, i_rom_data, i_xdata_wdata, o_xdata_rdata;
  logic [7:0] i_p3_alt_out, o_p3_alt_in, o_port1_extra_interrupt_inputs;
  logic [7:0] mem_data, wr_data, xrd;
  logic [15:0] i_pc_value, o_fetch_addr, i_xdata_addr, wr_addr;
  logic [11:0] o_rom_addr;
  int fail_count = 0;
  int checks = 0;
  int cycles = 0;
  row_t rows [5] = '{
    '{1'b1, 16'h0800, 1'b1, 8'h16},
    '{1'b1, 16'h0ff0, 1'b1, 8'h69},
    '{1'b1, 16'h1000, 1'b0, 8'h2c},
    '{1'b0, 16'h0200, 1'b0, 8'h3e},
    '{1'b1, 16'hf000, 1'b0, 8'hcc}
  };
  assign i_rom_data = o_rom_addr[11:4] ^ 8'h96;
  // Released lines read high through board pull-ups.
  assign rel_lvl = mem_drive ? {~ext_low[31:8], mem_data} : ~ext_low;
  assign i_pin = (o_pin_oe & o_pin_out) | (~o_pin_oe & rel_lvl);
  port_io_and_memory_expansion i_dut (.*);
  ext_mem_model i_mem (.i_core_clk, .i_wire(i_pin), .i_ale(o_address_latch_enable),
    .i_program_store_strobe_n(o_program_store_strobe_n), .o_data(mem_data), .o_drive(mem_drive),
    .o_wr_addr(wr_addr), .o_wr_data(wr_data));
  initial begin
    i_core_clk = 1'b0;
    forever #5 i_core_clk = ~i_core_clk;
  end
  task automatic chk(input string n, input logic [31:0] s, input logic [31:0] e);
    checks++;
    if (s !== e) begin
      fail_count++;
      $display("wrong value %s expected %h seen %h", n, e, s);
    end
  endtask : chk
  task automatic step();
    @(posedge i_core_clk);
    #1;
  endtask : step
  task automatic wait_valid();
    do step(); while (o_code_valid !== 1'b1);
  endtask : wait_valid
  task automatic do_reset();
    i_reset = 1'b1;
    repeat (20) step();
    i_reset = 1'b0;
    repeat (2) step();
  endtask : do_reset
  task automatic bit_write(input logic [4:0] s, input logic v);
    i_bit_we = 1'b1;
    i_bit_sel = s;
    i_bit_wdata = v;
    step();
    i_bit_we = 1'b0;
    step();
  endtask : bit_write
  // The request stays up until done is seen, then drops before the next cycle start.
  task automatic xfer(input logic wr, input logic [15:0] a, input logic [7:0] d);
    i_xdata_req = 1'b1;
    i_xdata_write = wr;
    i_xdata_addr = a;
    i_xdata_wdata = d;
    do step(); while (o_xdata_done !== 1'b1);
    xerr = o_xdata_error;
    xrd = o_xdata_rdata;
    i_xdata_req = 1'b0;
    step();
  endtask : xfer
  task automatic end_of_test();
    $display("checks %0d fail_count %0d", checks, fail_count);
    if (fail_count == 0 && checks > 0) $display("ALL TESTS PASSED");
    else $display("TESTS FAILED");
    $finish;
  endtask : end_of_test
  always @(posedge i_core_clk) begin
    cycles++;
    if (cycles == 20000) begin
      fail_count++;
      end_of_test();
    end
  end
  initial begin
    i_reset = 1'b1;
    i_external_access_strap = 1'b1;
    i_post_reset_level = 32'hc0a5_00ff;
    i_pin_option = 64'h24_0000;
    {i_byte_we, i_byte_wdata, i_bit_we, i_bit_sel, i_bit_wdata, i_pc_load} = '0;
    {i_pc_value, i_xdata_req, i_xdata_write, i_xdata_addr, i_xdata_wdata, ext_low} = '0;
    i_p3_alt_out = 8'hff;
    do_reset();
    chk("fetch_addr", o_fetch_addr, 32'h0);
    chk("latch", o_port_latch, 32'hc0a5_00ff);
    wait_valid();
    chk("first_code", o_code_byte, 32'h96);
    $display("test reset done");
    foreach (rows[k]) begin
      i_external_access_strap = rows[k].strap;
      i_pc_load = 1'b1;
      i_pc_value = rows[k].pc;
      step();
      i_pc_load = 1'b0;
      repeat (3) wait_valid();
      chk("internal", o_fetch_internal, rows[k].intl);
      chk("code", o_code_byte, rows[k].code);
    end
    $display("test fetch table done");
    xfer(1'b1, 16'h1234, 8'h5a);
    chk("wr_addr", wr_addr, 32'h1234);
    chk("wr_data", wr_data, 32'h5a);
    xfer(1'b0, 16'h4321, 8'h00);
    chk("rd_data", xrd, 32'h62);
    $display("test data access done");
    i_byte_we = 4'h2;
    i_byte_wdata = 8'hff;
    step();
    i_byte_we = 4'h0;
    step();
    chk("port1", o_port_latch[15:8], 32'hff);
    bit_write(5'd9, 1'b0);
    chk("port1_bit", o_port_latch[15:8], 32'hfd);
    ext_low[11] = 1'b1;
    repeat (3) step();
    chk("pin11", o_port_pins[11], 32'h0);
    chk("irq3", o_port1_extra_interrupt_inputs[3], 32'h0);
    ext_low[11] = 1'b0;
    $display("test latches done");
    bit_write(5'd30, 1'b0);
    xfer(1'b1, 16'h0055, 8'h77);
    chk("gated_wr", o_port_pins[30], 32'h0);
    bit_write(5'd30, 1'b1);
    chk("alt_gated", o_port_pins[24], 32'h0);
    i_p3_alt_out = 8'hfe;
    bit_write(5'd24, 1'b1);
    step();
    chk("alt_low", o_port_pins[24], 32'h0);
    i_p3_alt_out = 8'hff;
    repeat (2) step();
    chk("alt_high", o_port_pins[24], 32'h1);
    $display("test strobe gate done");
    i_pin_option[1:0] = 2'h2;
    do_reset();
    chk("blocked", o_ext_blocked, 32'h1);
    xfer(1'b0, 16'h0001, 8'h00);
    chk("error", xerr, 32'h1);
    $display("test blocked done");
    end_of_test();
  end
endmodule : test_port_io_and_memory_expansion
